/* sfm_cfg.svh */
// sfm_cfg.svh: widths, field positions, reset values and counts for the
// serial field memory transfer control block.
// assumes: included by bare name from every design file that needs it.
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH

// serial address format
`define SFM_ADDR_BITS       8
`define SFM_COL_BITS        6
`define SFM_MODE_HI_POS     7
`define SFM_MODE_LO_POS     6

// data organisation
`define SFM_WORD_BITS       12
`define SFM_BLOCK_WORDS     16
`define SFM_ROWS            212
`define SFM_COLS            64

// counts
`define SFM_INIT_RE_CYCLES  8
`define SFM_SYNC_STAGES     2

// reset values
`define SFM_ROW_RST         8'h00
`define SFM_COLMODE_RST     8'h00
`define SFM_INIT_CNT_RST    4'h0

`endif

/* sfm_pkg.sv */
// sfm_pkg.sv: types shared by the serial field memory transfer control.
// assumes: compiled before every module of the block.
package sfm_pkg;

  // operation selected by the two mode bits (hi, lo)
  typedef enum logic [1:0] {
    SFM_MODE_RD_A    = 2'h0,
    SFM_MODE_RD_B    = 2'h1,
    SFM_MODE_WR_C    = 2'h2,
    SFM_MODE_REFRESH = 2'h3
  } sfm_mode_t;

  // ram-enable cycle tracker, one-hot
  typedef enum logic [1:0] {
    SFM_RE_IDLE = 2'h1,
    SFM_RE_LOW  = 2'h2
  } sfm_re_state_t;

endpackage : sfm_pkg

/* sfm_addr_rx.sv */
// sfm_addr_rx.sv: serial row and column/mode receiver on the address clock.
// assumes: the address clock stops before ram-enable falls, so the parallel
// outputs are quasi-static when the core clock captures them.
`timescale 1ns/1ps
`include "sfm_cfg.svh"

module sfm_addr_rx
  import sfm_pkg::*;
#(
  parameter int BITS = `SFM_ADDR_BITS
) (
  input  wire logic            i_addr_shift_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_row_addr_in,
  input  wire logic            i_col_mode_in,
  output logic      [BITS-1:0] o_row,
  output logic      [BITS-1:0] o_col_mode
);

  logic [BITS-1:0] row_q;
  logic [BITS-1:0] col_q;
  logic [BITS-1:0] row_d;
  logic [BITS-1:0] col_d;

  // lsb first: each new bit enters at the top and moves down
  assign row_d = {i_row_addr_in, row_q[BITS-1:1]};
  assign col_d = {i_col_mode_in, col_q[BITS-1:1]};

  always_ff @(posedge i_addr_shift_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      row_q <= `SFM_ROW_RST;
      col_q <= `SFM_COLMODE_RST;
    end else begin
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  assign o_row      = row_q;
  assign o_col_mode = col_q;

endmodule : sfm_addr_rx

/* sfm_shift_port.sv */
// sfm_shift_port.sv: 16-word output shift register with its own shift clock.
// assumes: the latch bus is stable around the load strobe (the forbidden
// window keeps memory transfers away from it).
`timescale 1ns/1ps
`include "sfm_cfg.svh"

module sfm_shift_port
  import sfm_pkg::*;
#(
  parameter int W = `SFM_WORD_BITS,
  parameter int N = `SFM_BLOCK_WORDS
) (
  input  wire logic           i_shift_clk,
  input  wire logic           i_resetn,
  input  wire logic           i_load_n,
  input  wire logic [N*W-1:0] i_latch,
  output logic      [W-1:0]   o_dout
);

  localparam int PW = $clog2(N);

  logic [1:0]    load_sync_q;
  logic          load_prev_q;
  logic [W-1:0]  data_q [N];
  logic [PW-1:0] ptr_q;
  logic [W-1:0]  dout_q;
  logic          load_fall;

  assign load_fall = load_prev_q & ~load_sync_q[1];

  always_ff @(posedge i_shift_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      load_sync_q <= 2'h3;
      load_prev_q <= 1'b1;
    end else begin
      load_sync_q <= {load_sync_q[0], i_load_n};
      load_prev_q <= load_sync_q[1];
    end
  end

  // a load restarts the block at word 0
  generate
    for (genvar i = 0; i < N; i++) begin : g_word
      always_ff @(posedge i_shift_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          data_q[i] <= '0;
        end else if (load_fall) begin
          data_q[i] <= i_latch[i*W +: W];
        end
      end
    end
  endgenerate

  // the pointer wraps at 16, so an unreloaded block repeats
  always_ff @(posedge i_shift_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_q  <= '0;
      dout_q <= '0;
    end else if (load_fall) begin
      ptr_q  <= PW'(1);
      dout_q <= i_latch[W-1:0];
    end else begin
      ptr_q  <= ptr_q + PW'(1);
      dout_q <= data_q[ptr_q];
    end
  end

  assign o_dout = dout_q;

endmodule : sfm_shift_port

/* sfm_top.sv */
// sfm_top.sv: addressing, mode decoding and transfer control of a
// triple-port sequential field memory.
// assumes: address, port A and port B/C clocks are unrelated to i_clk; the
// controller honours the forbidden windows so latch buses are quasi-static.
//
// Summary of operation
// - row and column/mode shift in lsb first
// - ram-enable fall latches both serial addresses
// - six column bits, top two bits select mode
// - modes: read A, read B, write C, refresh
// - read modes copy memory into latch A or B
// - port A load fall copies latch A out
// - port B load fall copies latch B out
// - port A shifts, repeats 16 words unreloaded
// - port A data stays driven; o_port_a_dout_en drops while enable deasserted
// - port A clock independent of B/C clock
// - port B shifts, repeats; clock shared with C
// - refresh ignores external row and column
// - loads start blocks, store ends input block
// - strobes free except near memory transfers
// - port C store fall copies shifter into latch C
// - write mode stores latch C at ram-enable rise
// - port C keeps only the latest 16 words
`timescale 1ns/1ps
`include "sfm_cfg.svh"

module sfm_top
  import sfm_pkg::*;
#(
  parameter int W    = `SFM_WORD_BITS,
  parameter int N    = `SFM_BLOCK_WORDS,
  parameter int ROWS = `SFM_ROWS
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_addr_shift_clk,
  input  wire logic         i_row_addr_in,
  input  wire logic         i_col_mode_in,
  input  wire logic         i_ram_enable_n,
  input  wire logic         i_port_a_shift_clk,
  input  wire logic         i_port_a_load_n,
  input  wire logic         i_port_a_oe_n,
  input  wire logic         i_port_bc_shift_clk,
  input  wire logic         i_port_b_load_n,
  input  wire logic         i_port_c_store_n,
  input  wire logic [W-1:0] i_port_c_din,
  output logic      [W-1:0] o_port_a_dout,
  output logic              o_port_a_dout_en,
  output logic      [W-1:0] o_port_b_dout,
  output logic              o_init_ready
);

  localparam int AB    = `SFM_ADDR_BITS;
  localparam int CB    = `SFM_COL_BITS;
  localparam int IDXW  = AB + CB;
  localparam int DEPTH = ROWS * `SFM_COLS;
  localparam int BLK   = N * W;

  //////////////////////////////////////////////////////////////////////////
  // address receiver on the address clock
  logic [AB-1:0] rx_row;
  logic [AB-1:0] rx_col_mode;

  sfm_addr_rx #(
    .BITS (AB)
  ) u_addr_rx (
    .i_addr_shift_clk (i_addr_shift_clk),
    .i_resetn         (i_resetn),
    .i_row_addr_in    (i_row_addr_in),
    .i_col_mode_in    (i_col_mode_in),
    .o_row            (rx_row),
    .o_col_mode       (rx_col_mode)
  );

  //////////////////////////////////////////////////////////////////////////
  // ram-enable and port A enable synchronisers
  logic [1:0]    re_sync_q;
  logic [1:0]    oe_sync_q;
  sfm_re_state_t re_state_q;
  sfm_re_state_t re_state_d;
  logic          re_fall;
  logic          re_rise;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      re_sync_q <= 2'h3;
      oe_sync_q <= 2'h3;
    end else begin
      re_sync_q <= {re_sync_q[0], i_ram_enable_n};
      oe_sync_q <= {oe_sync_q[0], i_port_a_oe_n};
    end
  end

  assign re_fall = (re_state_q == SFM_RE_IDLE) & ~re_sync_q[1];
  assign re_rise = (re_state_q == SFM_RE_LOW) & re_sync_q[1];

  always_comb begin
    re_state_d = re_state_q;
    case (re_state_q)
      SFM_RE_IDLE: if (re_fall) re_state_d = SFM_RE_LOW;
      SFM_RE_LOW:  if (re_rise) re_state_d = SFM_RE_IDLE;
      default:     re_state_d = SFM_RE_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) re_state_q <= SFM_RE_IDLE;
    else           re_state_q <= re_state_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // address latch and mode decode
  logic [AB-1:0]   row_q;
  logic [CB-1:0]   col_q;
  sfm_mode_t       mode_q;
  sfm_mode_t       rx_mode;
  logic [IDXW-1:0] rx_idx;
  logic [IDXW-1:0] idx_q;
  logic            rx_in_range;
  logic            idx_in_range_q;

  // column is the low six bits, mode the last two shifted
  assign rx_mode = sfm_mode_t'({rx_col_mode[`SFM_MODE_HI_POS],
                                rx_col_mode[`SFM_MODE_LO_POS]});
  assign rx_idx      = {rx_row, rx_col_mode[CB-1:0]};
  assign rx_in_range = rx_idx < IDXW'(DEPTH);

  // captured once per cycle at the fall; the address clock is idle then
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      row_q          <= `SFM_ROW_RST;
      col_q          <= '0;
      mode_q         <= SFM_MODE_RD_A;
      idx_q          <= '0;
      idx_in_range_q <= 1'b0;
    end else if (re_fall) begin
      row_q          <= rx_row;
      col_q          <= rx_col_mode[CB-1:0];
      mode_q         <= rx_mode;
      idx_q          <= rx_idx;
      idx_in_range_q <= rx_in_range;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // memory array, latches A and B, refresh row counter
  logic [BLK-1:0] mem_q [DEPTH];
  logic [BLK-1:0] rd_word;
  logic [BLK-1:0] latch_a_q;
  logic [BLK-1:0] latch_b_q;
  logic [BLK-1:0] latch_c_q;
  logic [AB-1:0]  ref_row_q;
  logic           rd_a_en;
  logic           rd_b_en;
  logic           ref_en;
  logic           wr_en;

  // rows past the array read as zero and take no writes
  assign rd_word = rx_in_range ? mem_q[rx_idx[$clog2(DEPTH)-1:0]] : '0;
  assign rd_a_en = re_fall & (rx_mode == SFM_MODE_RD_A);
  assign rd_b_en = re_fall & (rx_mode == SFM_MODE_RD_B);
  assign ref_en  = re_fall & (rx_mode == SFM_MODE_REFRESH);
  assign wr_en   = re_rise & (mode_q == SFM_MODE_WR_C) & idx_in_range_q;

  // latch C belongs to the B/C domain; the write window keeps it stable
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem_q[idx_q[$clog2(DEPTH)-1:0]] <= latch_c_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_a_q <= '0;
      latch_b_q <= '0;
    end else begin
      if (rd_a_en) latch_a_q <= rd_word;
      if (rd_b_en) latch_b_q <= rd_word;
    end
  end

  // refresh walks an internal row and leaves latches and memory alone
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)   ref_row_q <= `SFM_ROW_RST;
    else if (ref_en) ref_row_q <= ref_row_q + AB'(1);
  end

  //////////////////////////////////////////////////////////////////////////
  // power-up: ready after eight ram-enable cycles
  logic [3:0] init_cnt_q;
  logic       init_done;

  assign init_done = init_cnt_q == 4'(`SFM_INIT_RE_CYCLES);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)                  init_cnt_q <= `SFM_INIT_CNT_RST;
    else if (re_rise && !init_done) init_cnt_q <= init_cnt_q + 4'h1;
  end

  assign o_init_ready = init_done;

  //////////////////////////////////////////////////////////////////////////
  // port A enable
  logic oe_q;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) oe_q <= 1'b0;
    else           oe_q <= ~oe_sync_q[1];
  end

  assign o_port_a_dout_en = oe_q;

  //////////////////////////////////////////////////////////////////////////
  // output ports; A runs on its own clock, B on the shared B/C clock
  sfm_shift_port #(
    .W (W),
    .N (N)
  ) u_port_a (
    .i_shift_clk (i_port_a_shift_clk),
    .i_resetn    (i_resetn),
    .i_load_n    (i_port_a_load_n),
    .i_latch     (latch_a_q),
    .o_dout      (o_port_a_dout)
  );

  sfm_shift_port #(
    .W (W),
    .N (N)
  ) u_port_b (
    .i_shift_clk (i_port_bc_shift_clk),
    .i_resetn    (i_resetn),
    .i_load_n    (i_port_b_load_n),
    .i_latch     (latch_b_q),
    .o_dout      (o_port_b_dout)
  );

  //////////////////////////////////////////////////////////////////////////
  // input port C on the shared B/C clock
  logic [1:0]     st_sync_q;
  logic           st_prev_q;
  logic           st_fall;
  logic [BLK-1:0] c_shift_q;
  logic [BLK-1:0] c_shift_d;

  // newest word enters at the top; the oldest drops off the bottom
  assign c_shift_d = {i_port_c_din, c_shift_q[BLK-1:W]};
  assign st_fall   = st_prev_q & ~st_sync_q[1];

  always_ff @(posedge i_port_bc_shift_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_sync_q <= 2'h3;
      st_prev_q <= 1'b1;
      c_shift_q <= '0;
      latch_c_q <= '0;
    end else begin
      st_sync_q <= {st_sync_q[0], i_port_c_store_n};
      st_prev_q <= st_sync_q[1];
      c_shift_q <= c_shift_d;
      if (st_fall) latch_c_q <= c_shift_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  sequence re_fall_s;
    re_fall;
  endsequence

  sequence re_cycle_s;
    re_fall ##1 (re_state_q == SFM_RE_LOW);
  endsequence

  property p_read_a;
    @(posedge i_clk) disable iff (!i_resetn)
      re_fall_s ##0 (rx_mode == SFM_MODE_RD_A) |=>
        latch_a_q == $past(rd_word);
  endproperty

  read_a_latch_a: assert property (p_read_a)
    else $error("latch A not loaded on read A");

  read_b_latch_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      rd_b_en |=> latch_b_q == $past(rd_word) && $stable(latch_a_q))
    else $error("latch B not loaded on read B");

  mode_capture_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      re_cycle_s |-> mode_q == $past(rx_mode) && row_q == $past(rx_row)
                     && col_q == $past(rx_col_mode[CB-1:0]))
    else $error("address or mode not latched at ram-enable fall");

  refresh_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      ref_en |=> $stable(latch_a_q) && $stable(latch_b_q)
                 && ref_row_q == $past(ref_row_q) + AB'(1))
    else $error("refresh disturbed latches or row counter");

  write_no_read_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      re_fall && rx_mode == SFM_MODE_WR_C |=>
        $stable(latch_a_q) && $stable(latch_b_q))
    else $error("write-mode fall disturbed a read latch");

  write_taken_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      re_rise && mode_q == SFM_MODE_WR_C && idx_in_range_q |=>
        mem_q[idx_q[$clog2(DEPTH)-1:0]] == $past(latch_c_q))
    else $error("write-mode rise did not store latch C");

  init_count_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      re_rise && !init_done |=> init_cnt_q == $past(init_cnt_q) + 4'h1)
    else $error("init counter missed a ram-enable cycle");

  init_sticky_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      o_init_ready |=> o_init_ready)
    else $error("ready dropped after init");

  port_a_float_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
      oe_sync_q[1] [*2] |-> !o_port_a_dout_en)
    else $error("port A driven while enable deasserted");

  store_latch_c_a: assert property (
    @(posedge i_port_bc_shift_clk) disable iff (!i_resetn)
      st_fall |=> latch_c_q == $past(c_shift_q))
    else $error("latch C not loaded at store strobe");

  keep_latest_a: assert property (
    @(posedge i_port_bc_shift_clk) disable iff (!i_resetn)
      1'b1 |=> c_shift_q[BLK-1 -: W] == $past(i_port_c_din))
    else $error("port C did not take the newest word");

endmodule : sfm_top

/* sfm_ctrl_model.sv */
// sfm_ctrl_model.sv: behavioural video memory controller driving the serial
// address link and the ram-enable strobe of the transfer control block.
// assumes: i_clk is the core clock; the testbench calls xfer hierarchically.
`timescale 1ns/1ps

module sfm_ctrl_model
  import sfm_pkg::*;
(
  input  wire logic i_clk,
  output logic      o_addr_shift_clk,
  output logic      o_row_addr_in,
  output logic      o_col_mode_in,
  output logic      o_ram_enable_n
);

  initial begin
    o_addr_shift_clk = 1'h0;
    o_row_addr_in    = 1'h0;
    o_col_mode_in    = 1'h0;
    o_ram_enable_n   = 1'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // one address cycle, then one ram-enable cycle; the address clock only
  // runs inside the frame, and the bit lines flip once hold time is over
  // so a stale level can never pass for a correctly shifted bit
  task automatic xfer(input logic [7:0] row,
                      input logic [5:0] col,
                      input sfm_mode_t  mode);
    logic [7:0] cm;
    cm = {mode, col};
    for (int i = 0; i < 8; i++) begin
      o_row_addr_in = row[i];
      o_col_mode_in = cm[i];
      #12 o_addr_shift_clk = 1'h1;
      #24 o_addr_shift_clk = 1'h0;
      #12;
    end
    o_row_addr_in = ~row[7];
    o_col_mode_in = ~cm[7];
    @(negedge i_clk);
    o_ram_enable_n = 1'h0;
    repeat (4) @(negedge i_clk);
    o_ram_enable_n = 1'h1;
    repeat (4) @(negedge i_clk);
  endtask : xfer

endmodule : sfm_ctrl_model

/* sfm_top_tb.sv */
// sfm_top_tb.sv: self-checking bench for the field memory transfer control.
// assumes: sfm_pkg and sfm_ctrl_model are compiled first; port clocks run
// free, the address clock only inside address frames.
`timescale 1ns/1ps

module sfm_top_tb
  import sfm_pkg::*;
;
  logic        i_clk;
  logic        i_resetn;
  logic        pa_clk;
  logic        bc_clk;
  logic        a_load_n;
  logic        oe_n;
  logic        b_load_n;
  logic        c_store_n;
  logic [11:0] c_din;
  logic [11:0] v1;
  logic [11:0] v2;
  logic [11:0] v3;
  wire logic   addr_clk;
  wire logic   row_in;
  wire logic   col_in;
  wire logic   re_n;
  wire logic [11:0] a_dout;
  wire logic [11:0] b_dout;
  wire logic   a_en;
  wire logic   init_rdy;
  int          error_cnt;
  int          tests_run;

  sfm_top uut (
    .i_clk               (i_clk),
    .i_resetn            (i_resetn),
    .i_addr_shift_clk    (addr_clk),
    .i_row_addr_in       (row_in),
    .i_col_mode_in       (col_in),
    .i_ram_enable_n      (re_n),
    .i_port_a_shift_clk  (pa_clk),
    .i_port_a_load_n     (a_load_n),
    .i_port_a_oe_n       (oe_n),
    .i_port_bc_shift_clk (bc_clk),
    .i_port_b_load_n     (b_load_n),
    .i_port_c_store_n    (c_store_n),
    .i_port_c_din        (c_din),
    .o_port_a_dout       (a_dout),
    .o_port_a_dout_en    (a_en),
    .o_port_b_dout       (b_dout),
    .o_init_ready        (init_rdy)
  );

  sfm_ctrl_model ctl (
    .i_clk            (i_clk),
    .o_addr_shift_clk (addr_clk),
    .o_row_addr_in    (row_in),
    .o_col_mode_in    (col_in),
    .o_ram_enable_n   (re_n)
  );

  //////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end
  // port A runs on its own unrelated period
  initial begin
    pa_clk = 1'h0;
    #7;
    forever #18 pa_clk = ~pa_clk;
  end
  initial begin
    bc_clk = 1'h0;
    #11;
    forever #24 bc_clk = ~bc_clk;
  end
  // counting stream so any lost or duplicated word shows up
  always @(negedge bc_clk) c_din <= c_din + 12'h001;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [11:0] seen,
                     input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // v is the newest of the 16 words that reach latch C; the strobe is
  // only called between ram-enable cycles
  task automatic store_c(input int skip, output logic [11:0] v);
    repeat (skip) @(negedge bc_clk);
    c_store_n <= 1'h0;
    // the strobe sync lags two shift edges, so one more word gets in
    #1 v = c_din + 12'h001;
    repeat (3) @(negedge bc_clk);
    c_store_n <= 1'h1;
    repeat (3) @(negedge bc_clk);
  endtask : store_c

  // loads a port, then checks 20 words: one block plus the wrap-around
  task automatic chk_port(input bit b, input logic [11:0] v);
    if (b) @(negedge bc_clk); else @(negedge pa_clk);
    if (b) b_load_n <= 1'h0; else a_load_n <= 1'h0;
    for (int i = 1; i < 23; i++) begin
      if (b) @(negedge bc_clk); else @(negedge pa_clk);
      if (i == 3) begin
        a_load_n <= 1'h1;
        b_load_n <= 1'h1;
      end
      if (i >= 3)
        chk(b ? "port_b" : "port_a", b ? b_dout : a_dout,
            v - 12'h00F + 12'((i - 3) % 16));
    end
  endtask : chk_port

  task automatic chk_oe(input logic oe, input logic exp);
    @(negedge i_clk) oe_n <= oe;
    repeat (4) @(negedge i_clk);
    chk("port_a_en", {11'h000, a_en}, {11'h000, exp});
  endtask : chk_oe

  //////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    tests_run = 0;
    i_resetn  = 1'h0;
    a_load_n  = 1'h1;
    oe_n      = 1'h1;
    b_load_n  = 1'h1;
    c_store_n = 1'h1;
    c_din     = 12'h000;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'h1;
    chk("port_a_en", {11'h000, a_en}, 12'h000);
    repeat (2) @(negedge i_clk);
    // ready must stay low until the eighth cycle has completed
    for (int i = 0; i < 8; i++) begin
      chk("init_ready", {11'h000, init_rdy}, 12'h000);
      ctl.xfer(8'hA5, 6'h2A, SFM_MODE_REFRESH);
    end
    chk("init_ready", {11'h000, init_rdy}, 12'h001);
    chk_oe(1'h0, 1'h1);
    chk_oe(1'h1, 1'h0);
    chk_oe(1'h0, 1'h1);
    store_c(1, v1);
    ctl.xfer(8'h05, 6'h03, SFM_MODE_WR_C);
    store_c(1, v2);
    ctl.xfer(8'hD3, 6'h3F, SFM_MODE_WR_C);
    // main cycle order: latch A, latch B, latch A
    ctl.xfer(8'h05, 6'h03, SFM_MODE_RD_A);
    ctl.xfer(8'hD3, 6'h3F, SFM_MODE_RD_B);
    ctl.xfer(8'h05, 6'h03, SFM_MODE_RD_A);
    chk_port(1'h0, v1);
    chk_port(1'h1, v2);
    store_c(3, v3);
    // latch C now differs from memory; refresh must not store it
    ctl.xfer(8'h05, 6'h03, SFM_MODE_REFRESH);
    ctl.xfer(8'h05, 6'h03, SFM_MODE_RD_A);
    chk_port(1'h0, v1);
    ctl.xfer(8'hD3, 6'h3F, SFM_MODE_WR_C);
    ctl.xfer(8'hD3, 6'h3F, SFM_MODE_RD_B);
    chk_port(1'h1, v3);
    finish_test();
  end

  // a hang counts as a mismatch and still reaches the verdict
  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

endmodule : sfm_top_tb
